// ### logic/seq_params.svh
// Offsets, field positions, reset values and timing for the mode sequencer
// How it works
// - Three modes chosen by two-bit mode field
// - Power-on reset leaves device in sleep
// - Sleep measures nothing, registers stay accessible
// - Forced runs one measurement, then sleeps
// - Normal repeats measurement then standby forever
// - Three-bit standby select, 0.5 to 1000 ms
// - Mode change during measurement waits for end
// - While pending, ignore mode and humidity writes
// - Normal mode refreshes data every cycle
// - Measurement is temperature, pressure, humidity, each oversampled
// - Filter only on pressure and temperature
// - Humidity skippable, three-bit oversampling, 16-bit result
// - Pressure 20 bits filtered, else 15+osrs
// - Temperature likewise, and skippable
// - Filter: (old*(c-1)+adc)/c, stored and output
// - Coefficient off, 2, 4, 8 or 16
// - Filter write resets; next sample loads memory
// - Skipped temp or press channel keeps memory, outputs 0x80000
// - Re-enabled channel resumes from kept memory
// - Soft reset command restores reset state
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH
`define OFS_CTRL_MEAS 8'h00
`define OFS_CONFIG    8'h04
`define OFS_CTRL_HUM  8'h08
`define OFS_STATUS    8'h0c
`define OFS_RESET     8'h10
`define OFS_PRESS     8'h14
`define OFS_TEMP      8'h18
`define OFS_HUM       8'h1c
`define OFS_ID        8'h20
`define MODE_LSB      0
`define OSRS_P_LSB    2
`define OSRS_T_LSB    5
`define FILT_LSB      0
`define SB_LSB        5
`define OSRS_H_LSB    0
`define MODE_SLEEP    2'h0
`define MODE_NORMAL   2'h3
`define SKIP_VALUE    20'h80000
`define RESET_KEY     8'hb6
`define CHIP_ID       8'h5a // Arbitrary value
`define CLK_MHZ       25
`define SB_US_0       500
`define SB_US_1       1000
`define SB_US_2       2000
`define SB_US_3       5000
`define SB_US_4       10000
`define SB_US_5       100000
`define SB_US_6       500000
`define SB_US_7       1000000
`endif

// ### logic/seq_pkg.sv
// Types of the measurement mode sequencer
package seq_pkg;
    typedef enum logic [1:0] {st_idle, st_start, st_wait, st_standby} meas_state_e;
    typedef struct packed {
        meas_state_e      st;
        logic [1:0]       chan;
        logic [1:0]       mode;
        logic [1:0]       pend_mode;
        logic             pend;
        logic [2:0]       osrs_p;
        logic [2:0]       osrs_t;
        logic [2:0]       osrs_h;
        logic [2:0]       filt;
        logic [2:0]       sb;
        logic [1:0]       init;
        logic [1:0][19:0] mem;
        logic [1:0][19:0] outv;
        logic [15:0]      hum;
        logic [24:0]      sb_cnt;
        logic             ready;
        logic             slverr;
        logic             conv_start;
        logic [31:0]      rdata;
    } seq_state_s;
endpackage : seq_pkg

// ### logic/measurement_mode_sequencer.sv
// Measurement mode sequencer with APB registers and IIR filter
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "seq_params.svh"
module measurement_mode_sequencer #(
    parameter int unsigned standby_cycles [8] = '{
        `SB_US_0 * `CLK_MHZ, `SB_US_1 * `CLK_MHZ,
        `SB_US_2 * `CLK_MHZ, `SB_US_3 * `CLK_MHZ,
        `SB_US_4 * `CLK_MHZ, `SB_US_5 * `CLK_MHZ,
        `SB_US_6 * `CLK_MHZ, `SB_US_7 * `CLK_MHZ}
) (
    input  wire logic        pclk,       // 25 MHz clock
    input  wire logic        presetn,    // Async reset, low
    input  wire logic        ce,         // Clock enable
    input  wire logic        psel,       // APB select
    input  wire logic        penable,    // APB enable
    input  wire logic        pwrite,     // APB direction
    input  wire logic [7:0]  paddr,      // APB byte address
    input  wire logic [31:0] pwdata,     // APB write data
    output logic      [31:0] prdata,     // APB read data
    output logic             pready,     // APB ready
    output logic             pslverr,    // APB error
    output logic             conv_start, // Conversion request
    output logic      [1:0]  conv_chan,  // 0 temp, 1 press, 2 hum
    output logic      [2:0]  conv_osrs,  // Oversampling of request
    output logic             measuring,  // Measurement period busy
    input  wire logic        adc_valid,  // Conversion done pulse
    input  wire logic [19:0] adc_data    // Raw conversion result
);
    seq_pkg::seq_state_s s;
    seq_pkg::seq_state_s n;

    // Oversampling setting of a channel
    function automatic logic [2:0] chan_osrs(
        input seq_pkg::seq_state_s v, input logic [1:0] c);
        case (c)
            2'h0:    chan_osrs = v.osrs_t;
            2'h1:    chan_osrs = v.osrs_p;
            default: chan_osrs = v.osrs_h;
        endcase
    endfunction : chan_osrs

    // Coefficient as a shift: off, 2, 4, 8, then 16 for settings 4 and above
    function automatic logic [2:0] coef_shift(input logic [2:0] f);
        coef_shift = (f > 3'h4) ? 3'h4 : f;
    endfunction : coef_shift

    // Unfiltered width is 15 + osrs bits, left aligned
    function automatic logic [19:0] res_mask(input logic [2:0] o);
        logic [2:0] drop;
        drop = (o >= 3'h5) ? 3'h0 : 3'h5 - o;
        res_mask = 20'hfffff << drop;
    endfunction : res_mask

    // One filter step, exact shift division
    function automatic logic [19:0] filt_step(
        input logic [19:0] old, input logic [19:0] adc,
        input logic [2:0] k);
        logic [24:0] acc;
        acc = ({5'h0, old} << k) - {5'h0, old} + {5'h0, adc};
        filt_step = 20'(acc >> k);
    endfunction : filt_step

    // Register offset decode, used by the error path only
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= `OFS_ID) && (a[1:0] == 2'h0);
    endfunction : mapped

    logic       acc_ph;
    logic       wr;
    logic       is_meas;
    logic [2:0] osrs_now;
    logic [2:0] k_now;

    assign acc_ph   = psel && penable && s.ready;
    assign wr       = acc_ph && pwrite && !s.slverr;
    assign is_meas  = (s.st == seq_pkg::st_start) || (s.st == seq_pkg::st_wait);
    assign osrs_now = chan_osrs(s, s.chan);
    assign k_now    = coef_shift(s.filt);

    // Next state: measurement flow first, bus writes after
    always_comb begin
        logic       done;
        logic       start_new;
        logic [1:0] m;
        n         = s;
        done      = 1'b0;
        start_new = 1'b0;
        m         = 2'h0;
        n.ready   = psel && !penable && !s.ready;
        if (psel && !penable) begin
            n.slverr = !mapped(paddr);
        end
        case (s.st)
            seq_pkg::st_idle: begin
            end
            seq_pkg::st_start: begin
                if (osrs_now == 3'h0) begin
                    // Skipped: memory untouched, marker out for temp and press only
                    if (s.chan != 2'h2) begin
                        n.outv[s.chan[0]] = `SKIP_VALUE;
                    end
                    done = 1'b1;
                end else begin
                    n.conv_start = 1'b1;
                    n.st         = seq_pkg::st_wait;
                end
            end
            seq_pkg::st_wait: begin
                // Request stands until its result is taken
                if (adc_valid) begin
                    n.conv_start = 1'b0;
                    done         = 1'b1;
                    if (s.chan == 2'h2) begin
                        n.hum = adc_data[15:0];
                    end else if (k_now == 3'h0) begin
                        n.outv[s.chan[0]] = adc_data & res_mask(osrs_now);
                        n.mem[s.chan[0]]  = adc_data;
                    end else if (s.init[s.chan[0]]) begin
                        n.outv[s.chan[0]] = adc_data;
                        n.mem[s.chan[0]]  = adc_data;
                        n.init[s.chan[0]] = 1'b0;
                    end else begin
                        // Resumes from whatever memory was kept
                        n.mem[s.chan[0]]  = filt_step(s.mem[s.chan[0]], adc_data, k_now);
                        n.outv[s.chan[0]] = n.mem[s.chan[0]];
                    end
                end
            end
            seq_pkg::st_standby: begin
                if (s.sb_cnt == 25'h0) begin
                    n.st   = seq_pkg::st_start;
                    n.chan = 2'h0;
                end else begin
                    n.sb_cnt = s.sb_cnt - 25'h1;
                end
            end
            default: n.st = seq_pkg::st_idle;
        endcase

        // End of a channel; end of period applies a deferred mode
        if (done) begin
            if (s.chan != 2'h2) begin
                n.chan = s.chan + 2'h1;
                n.st   = seq_pkg::st_start;
            end else begin
                m = s.mode;
                if (s.pend) begin
                    m         = s.pend_mode;
                    start_new = 1'b1;
                    n.pend    = 1'b0;
                end
                n.chan = 2'h0;
                if (m == `MODE_SLEEP) begin
                    n.st = seq_pkg::st_idle;
                end else if (m == `MODE_NORMAL) begin
                    n.st     = seq_pkg::st_standby;
                    n.sb_cnt = 25'(standby_cycles[s.sb] - 1);
                end else if (start_new) begin
                    n.st = seq_pkg::st_start;
                end else begin
                    // Single shot over, host must ask again
                    m    = `MODE_SLEEP;
                    n.st = seq_pkg::st_idle;
                end
                n.mode = m;
            end
        end

        // Register writes take effect at the access edge
        if (wr) begin
            case (paddr)
                `OFS_CTRL_MEAS: begin
                    n.osrs_p = pwdata[`OSRS_P_LSB +: 3];
                    n.osrs_t = pwdata[`OSRS_T_LSB +: 3];
                    if (s.pend) begin
                        n.pend = n.pend;
                    end else if (n.st == seq_pkg::st_start || n.st == seq_pkg::st_wait) begin
                        n.pend      = 1'b1;
                        n.pend_mode = pwdata[`MODE_LSB +: 2];
                    end else begin
                        n.mode = pwdata[`MODE_LSB +: 2];
                        n.chan = 2'h0;
                        case (pwdata[`MODE_LSB +: 2])
                            `MODE_SLEEP:  n.st = seq_pkg::st_idle;
                            `MODE_NORMAL: begin
                                if (s.mode != `MODE_NORMAL) begin
                                    n.st = seq_pkg::st_start;
                                end
                            end
                            default:      n.st = seq_pkg::st_start;
                        endcase
                    end
                end
                `OFS_CONFIG: begin
                    n.filt = pwdata[`FILT_LSB +: 3];
                    n.sb   = pwdata[`SB_LSB +: 3];
                    n.init = 2'h3;
                end
                `OFS_CTRL_HUM: begin
                    if (!s.pend) begin
                        n.osrs_h = pwdata[`OSRS_H_LSB +: 3];
                    end
                end
                `OFS_RESET: begin
                    if (pwdata[7:0] == `RESET_KEY) begin
                        n       = '0;
                        n.ready = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Read data captured in setup; any mode reads back
        if (psel && !penable) begin
            case (paddr)
                `OFS_CTRL_MEAS: n.rdata = {24'h0, s.osrs_t, s.osrs_p, s.mode};
                `OFS_CONFIG:    n.rdata = {24'h0, s.sb, 2'h0, s.filt};
                `OFS_CTRL_HUM:  n.rdata = {29'h0, s.osrs_h};
                `OFS_STATUS:    n.rdata = {30'h0, s.pend, is_meas};
                `OFS_PRESS:     n.rdata = {12'h0, s.outv[1]};
                `OFS_TEMP:      n.rdata = {12'h0, s.outv[0]};
                `OFS_HUM:       n.rdata = {16'h0, s.hum};
                `OFS_ID:        n.rdata = {24'h0, `CHIP_ID}; // Arbitrary value
                default:        n.rdata = 32'h0;
            endcase
        end
    end

    // State register; reset lands in sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else if (ce) begin
            s <= n;
        end
    end

    assign prdata     = s.rdata;
    assign pready     = s.ready;
    assign pslverr    = s.slverr;
    assign conv_start = s.conv_start;
    assign conv_chan  = s.chan;
    assign conv_osrs  = chan_osrs(s, s.chan);
    assign measuring  = is_meas;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic wr_meas;
    logic wr_cfg;
    logic wr_hum;
    logic last_done;
    assign wr_meas   = wr && ce && paddr == `OFS_CTRL_MEAS;
    assign wr_cfg    = wr && ce && paddr == `OFS_CONFIG;
    assign wr_hum    = wr && ce && paddr == `OFS_CTRL_HUM;
    assign last_done = ce && s.st == seq_pkg::st_wait && adc_valid && s.chan == 2'h2;

    sequence forced_last;
        last_done && !s.pend && !wr_meas && s.mode inside {2'h1, 2'h2};
    endsequence
    sequence back_asleep;
        s.mode == `MODE_SLEEP && s.st == seq_pkg::st_idle;
    endsequence

    a_sleep_quiet: assert property (s.mode == `MODE_SLEEP |-> !is_meas || s.pend)
        else $error("measuring in sleep");
    a_forced_return: assert property (forced_last |=> back_asleep)
        else $error("forced did not return to sleep");
    a_mode_defer: assert property (ce && s.st == seq_pkg::st_wait && !adc_valid && wr_meas
        && !s.pend |=> s.pend && s.mode == $past(s.mode))
        else $error("mode change not deferred");
    a_pend_ignore: assert property (s.pend && wr_hum && !last_done |=> $stable(s.osrs_h))
        else $error("humidity write taken while pending");
    a_skip_value: assert property (ce && s.st == seq_pkg::st_start && s.chan == 2'h1
        && s.osrs_p == 3'h0 |=> s.outv[1] == `SKIP_VALUE && $stable(s.mem))
        else $error("skip value wrong");
    a_filter_init: assert property (wr_cfg |=> s.init == 2'h3)
        else $error("filter not reset");
    a_standby_wake: assert property (ce && s.st == seq_pkg::st_standby && s.sb_cnt == 25'h0
        && !wr |=> s.st == seq_pkg::st_start && s.chan == 2'h0)
        else $error("standby did not restart");
    a_hum_raw: assert property (last_done |=> s.hum == $past(adc_data[15:0]))
        else $error("humidity altered");
    a_soft_reset: assert property (wr && ce && paddr == `OFS_RESET
        && pwdata[7:0] == `RESET_KEY |=> back_asleep ##0 s.filt == 3'h0)
        else $error("soft reset incomplete");
    a_conv_issue: assert property (ce && s.st == seq_pkg::st_start && osrs_now != 3'h0
        && !wr |=> conv_start && s.st == seq_pkg::st_wait)
        else $error("conversion not requested");
endmodule : measurement_mode_sequencer

// ### tb/adc_model.sv
// Conversion-side model: answers each request with the value of its channel
`timescale 1ns/1ns
module adc_model (
    input  wire logic        pclk,       // Clock
    input  wire logic        presetn,    // Async reset, low
    input  wire logic        conv_start, // Request level
    input  wire logic [1:0]  conv_chan,  // Requested channel
    input  wire logic        slow,       // Long conversions
    input  wire logic [19:0] val_t,      // Temperature result
    input  wire logic [19:0] val_p,      // Pressure result
    input  wire logic [19:0] val_h,      // Humidity result
    output logic             adc_valid,  // Result pulse
    output logic      [19:0] adc_data    // Result
);
    logic [4:0] cnt_q;
    logic       done_q;
    // One result per request; done blocks a restart while the request falls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q     <= 5'h00;
            done_q    <= 1'b0;
            adc_valid <= 1'b0;
            adc_data  <= 20'h00000;
        end else begin
            adc_valid <= 1'b0;
            adc_data  <= ~adc_data; // Released line inverts every cycle instead of holding the result
            if (cnt_q != 5'h00) begin
                cnt_q <= cnt_q - 5'h01;
                if (cnt_q == 5'h01) begin
                    adc_valid <= 1'b1;
                    done_q    <= 1'b1;
                    adc_data  <= (conv_chan == 2'h0) ? val_t : (conv_chan == 2'h1) ? val_p : val_h;
                end
            end else if (conv_start && !done_q) begin
                cnt_q <= slow ? 5'h14 : 5'h01;
            end
            if (!conv_start) begin
                done_q <= 1'b0;
            end
        end
    end
endmodule : adc_model

// ### tb/measurement_mode_sequencer_tb.sv
// Register-level testbench for the measurement mode sequencer
`timescale 1ns/1ns
`include "seq_params.svh"
module measurement_mode_sequencer_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready, pslverr, conv_start, measuring, adc_valid, slow = 1'b0;
    logic [1:0]  conv_chan;
    logic [2:0]  conv_osrs;
    logic [19:0] adc_data, val_t = 20'h00000, val_p = 20'h00000, val_h = 20'h00000;
    logic [31:0] rv;
    logic        ev;
    int          miscompares = 0, n_checks = 0, cyc = 0, n, k;

    measurement_mode_sequencer #(.standby_cycles('{4, 5, 6, 7, 8, 9, 10, 11})) measurement_mode_sequencer_inst (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_start(conv_start), .conv_chan(conv_chan), .conv_osrs(conv_osrs), .measuring(measuring),
        .adc_valid(adc_valid), .adc_data(adc_data));
    adc_model adc_model_inst (
        .pclk(pclk), .presetn(presetn), .conv_start(conv_start), .conv_chan(conv_chan), .slow(slow),
        .val_t(val_t), .val_p(val_p), .val_h(val_h), .adc_valid(adc_valid), .adc_data(adc_data));

    // Clock and a hang guard well above the expected run length
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", name, exp, got);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(name, exp, rv);
    endtask : rd

    task automatic wait_meas();
        while (measuring !== 1'b1) @(posedge pclk);
        while (measuring !== 1'b0) @(posedge pclk);
    endtask : wait_meas

    function automatic logic [31:0] ctl(input logic [2:0] t, input logic [2:0] p, input logic [1:0] m);
        return {24'h000000, t, p, m};
    endfunction : ctl

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Reset state, sleep behaviour, unmapped access
        rd("mode", `OFS_CTRL_MEAS, 32'h00000000);
        rd("id", `OFS_ID, {24'h000000, `CHIP_ID});
        rd("status", `OFS_STATUS, 32'h00000000);
        apb(1'b0, 8'h24, 32'h00000000);
        chk("slverr", 32'h00000001, {31'h0, ev});
        repeat (20) @(posedge pclk);
        chk("sleep", 32'h00000000, {31'h0, measuring});
        $display("test reset done");
        // Forced with filter off: widths follow oversampling
        val_t <= 20'h12345; val_p <= 20'habcde; val_h <= 20'h05678;
        apb(1'b1, `OFS_CONFIG, 32'h00000000);
        apb(1'b1, `OFS_CTRL_HUM, 32'h00000001);
        apb(1'b1, `OFS_CTRL_MEAS, ctl(3'h1, 3'h3, 2'h1));
        wait_meas();
        rd("mode", `OFS_CTRL_MEAS, ctl(3'h1, 3'h3, 2'h0));
        rd("temp", `OFS_TEMP, 32'h00012340);
        rd("press", `OFS_PRESS, 32'h000abcdc);
        rd("hum", `OFS_HUM, 32'h00005678);
        repeat (30) @(posedge pclk);
        chk("no rerun", 32'h00000000, {31'h0, measuring});
        $display("test forced done");
        // Each coefficient: reset loads memory, then one filtered step
        for (k = 1; k < 6; k++) begin
            apb(1'b1, `OFS_CONFIG, k);
            val_t <= 20'h20000; val_p <= 20'h00000; val_h <= 20'h01111;
            apb(1'b1, `OFS_CTRL_MEAS, ctl(3'h1, 3'h1, 2'h2));
            wait_meas();
            rd("temp init", `OFS_TEMP, 32'h00020000);
            val_p <= 20'h40000; val_h <= 20'h0beef;
            apb(1'b1, `OFS_CTRL_MEAS, ctl(3'h1, 3'h1, 2'h1));
            wait_meas();
            rd("press filt", `OFS_PRESS, 32'h00040000 >> (k > 4 ? 4 : k));
            rd("hum raw", `OFS_HUM, 32'h0000beef);
        end
        $display("test filter done");
        // Skip keeps memory; re-enable resumes from it
        val_p <= 20'h7ffff;
        apb(1'b1, `OFS_CTRL_MEAS, ctl(3'h1, 3'h0, 2'h1));
        wait_meas();
        rd("press skip", `OFS_PRESS, {12'h000, `SKIP_VALUE});
        val_p <= 20'h44000;
        apb(1'b1, `OFS_CTRL_MEAS, ctl(3'h1, 3'h1, 2'h1));
        wait_meas();
        rd("press resume", `OFS_PRESS, 32'h00008000);
        $display("test skip done");
        // Normal mode cycling, deferred mode change, ignored writes
        slow <= 1'b1;
        apb(1'b1, `OFS_CONFIG, 32'h00000000);
        apb(1'b1, `OFS_CTRL_MEAS, ctl(3'h1, 3'h1, 2'h3));
        wait_meas();
        val_p <= 20'h33333;
        n = 0;
        while (measuring !== 1'b1) begin
            @(posedge pclk);
            n++;
        end
        chk("standby", 32'h00000001, {31'h0, n >= 4});
        apb(1'b1, `OFS_CTRL_MEAS, ctl(3'h1, 3'h1, 2'h0));
        rd("pending", `OFS_STATUS, 32'h00000003);
        rd("mode eff", `OFS_CTRL_MEAS, ctl(3'h1, 3'h1, 2'h3));
        apb(1'b1, `OFS_CTRL_HUM, 32'h00000004);
        rd("hum ctl", `OFS_CTRL_HUM, 32'h00000001);
        while (measuring !== 1'b0) @(posedge pclk);
        rd("mode", `OFS_CTRL_MEAS, ctl(3'h1, 3'h1, 2'h0));
        rd("press new", `OFS_PRESS, 32'h00033330);
        repeat (40) @(posedge pclk);
        chk("stopped", 32'h00000000, {31'h0, measuring});
        $display("test normal done");
        // Soft reset returns config and mode registers to their reset values
        apb(1'b1, `OFS_CONFIG, 32'h000000e3);
        apb(1'b1, `OFS_RESET, {24'h000000, `RESET_KEY});
        rd("config", `OFS_CONFIG, 32'h00000000);
        rd("mode", `OFS_CTRL_MEAS, 32'h00000000);
        $display("test soft reset done");
        complete_run();
    end
endmodule : measurement_mode_sequencer_tb
